//--- core/siocr_pkg.sv
// Constants, field layouts and types for the sync, I/O and mode configuration registers.
// Contract
// RQ1: Role bit 0 slave, 1 master syncs.
// RQ2: Polarity bit 0 active low, 1 high.
// RQ3: Software keeps line sync rise at least 36.
// RQ4: Frame sync rises at upper edge field.
// RQ5: Software matches range bits to supplies.
// RQ6: Regulator enable bit drives 3.2 V output.
// RQ7: Horizontal clock config codes are one-hot only.
// RQ8: Pump clock from oscillator, divided or input.
// RQ9: Pump voltage select bits, 3.3 V default.
// RQ10: Pump power-down bit, resets to one.
// RQ11: Standby 1/2 and disabled use first polarity.
// RQ12: Standby 3 uses second vertical polarity.
// RQ13: General outputs take standby polarities per byte.
// RQ14: Pattern and sequence counts bound memory.
// RQ15: Step through configured fields per mode.
// RQ16: Seven selectors name field per position.
// RQ17: Software keeps reserved test bits at defaults.
// RQ18: Field-updated registers load at update line.
// RQ19: Control low holds outputs; high enables at frame.
// RQ20: Immediate registers now; polarity, edges at update.
// RQ21: Invalid horizontal clock code keeps previous value.
`default_nettype none
package siocr_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [5:0]  IDX_ROLE     = 6'h20;
	localparam logic [5:0]  IDX_POL      = 6'h21;
	localparam logic [5:0]  IDX_EDGE     = 6'h22;
	localparam logic [5:0]  IDX_IOCFG    = 6'h23;
	localparam logic [5:0]  IDX_PUMP     = 6'h24;
	localparam logic [5:0]  IDX_VSB12    = 6'h25;
	localparam logic [5:0]  IDX_VSB3     = 6'h26;
	localparam logic [5:0]  IDX_GPSB     = 6'h27;
	localparam logic [5:0]  IDX_COUNTS   = 6'h28;
	localparam logic [5:0]  IDX_MODE     = 6'h2a;
	localparam logic [5:0]  IDX_FSEL_LO  = 6'h2b;
	localparam logic [5:0]  IDX_FSEL_HI  = 6'h2c;
	localparam logic [5:0]  IDX_STATUS   = 6'h2d;
	localparam int          NUM_SLOTS    = 14;
	localparam logic [3:0]  SLOT_HOLE    = 4'h9;
	localparam logic [3:0]  SLOT_STATUS  = 4'hd;
	// Implemented bits of each register.
	localparam logic [31:0] MASK_BIT     = 32'h0000_0001;
	localparam logic [31:0] MASK_EDGE    = 32'h03ff_ffff;
	localparam logic [31:0] MASK_IOCFG   = 32'h0000_03ff;
	localparam logic [31:0] MASK_PUMP    = 32'h0000_7fff;
	localparam logic [31:0] MASK_VSB     = 32'h01ff_ffff;
	localparam logic [31:0] MASK_GPSB    = 32'h0000_ffff;
	localparam logic [31:0] MASK_COUNTS  = 32'h0000_03ff;
	localparam logic [31:0] MASK_MODE    = 32'h0000_0007;
	localparam logic [31:0] MASK_FSEL_HI = 32'h0000_03ff;
	// Reset values that are not zero.
	localparam logic [31:0] RST_IOCFG    = 32'h0000_0080;
	localparam logic [31:0] RST_PUMP     = 32'h0000_47a2;
	// Field positions.
	localparam int          LOC_W        = 13;
	localparam int          LSYNC_LSB    = 0;
	localparam int          FSYNC_LSB    = 13;
	localparam int          OSC_BIT      = 0;
	localparam int          VOUT_BIT     = 1;
	localparam int          IORNG_BIT    = 2;
	localparam int          DATA_BIT     = 3;
	localparam int          REGEN_BIT    = 6;
	localparam int          HCLK_LSB     = 7;
	localparam int          PUMP_OSC_BIT = 0;
	localparam int          PUMP_CLI_BIT = 2;
	localparam int          PUMP_V_LSB   = 3;
	localparam int          PUMP_PD_BIT  = 14;
	localparam int          GP3_LSB      = 8;
	localparam int          SEQ_LSB      = 5;
	localparam int          FSEL_W       = 5;
	localparam int          VERT_N       = 24;
	// Horizontal clock output configuration codes.
	localparam logic [2:0]  HCLK_MODE1   = 3'h1;
	localparam logic [2:0]  HCLK_MODE2   = 3'h2;
	localparam logic [2:0]  HCLK_MODE3   = 3'h4;
	// Charge-pump clock source codes on the output port.
	localparam logic [1:0]  PUMP_SRC_DIV = 2'h0;
	localparam logic [1:0]  PUMP_SRC_OSC = 2'h1;
	localparam logic [1:0]  PUMP_SRC_CLI = 2'h2;
	// Standby state codes.
	localparam logic [1:0]  STBY_NONE    = 2'h0;
	localparam logic [1:0]  STBY_3       = 2'h3;
	// Master sync generator timing, in pixel clocks and lines.
	localparam logic [12:0] LINE_PIXELS  = 13'h0618;
	localparam logic [12:0] FRAME_LINES  = 13'h041a;
	localparam logic [12:0] LSYNC_WIDTH  = 13'h0010;
	// Bus responses.
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	// Output gate states.
	typedef enum logic [2:0] {
		OUT_OFF   = 3'b001,
		OUT_ARMED = 3'b010,
		OUT_ON    = 3'b100
	} siocr_out_state_t;
endpackage
`default_nettype wire

//--- core/siocr_regs.sv
// Sync, I/O, charge-pump, standby and mode configuration registers with an AXI4-Lite slave.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module siocr_regs (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic        line_sync_in_i,
	output logic             line_sync_out_o,
	output logic             line_sync_oe_n_o,
	input  wire logic        frame_sync_in_i,
	output logic             frame_sync_out_o,
	output logic             frame_sync_oe_n_o,
	input  wire logic [12:0] update_line_i,
	input  wire logic        output_enable_ctl_i,
	input  wire logic [1:0]  standby_state_i,
	input  wire logic [23:0] vert_timing_i,
	input  wire logic        substrate_timing_i,
	input  wire logic [7:0]  general_timing_i,
	output logic [23:0]      vertical_clock_out_o,
	output logic             substrate_clock_out_o,
	output logic [7:0]       general_out_o,
	output logic             osc_range_sel_o,
	output logic             vert_out_range_sel_o,
	output logic             io_range_sel_o,
	output logic             data_pin_range_sel_o,
	output logic             regulator_enable_o,
	output logic [2:0]       hclk_out_config_o,
	output logic [1:0]       pump_clk_src_o,
	output logic [3:0]       pump_v_sel_o,
	output logic             pump_power_down_o,
	output logic [4:0]       pattern_group_count_o,
	output logic [4:0]       sequence_count_o,
	output logic [2:0]       field_position_o,
	output logic [4:0]       current_field_o
);
	// Maps a byte address to a register slot; unmapped addresses give the hole slot.
	function automatic logic [3:0] slot_of(input logic [7:0] addr);
		logic [5:0] idx;
		idx = addr[7:2];
		if (idx >= siocr_pkg::IDX_ROLE && idx <= siocr_pkg::IDX_STATUS) begin
			slot_of = 4'(idx - siocr_pkg::IDX_ROLE);
		end else begin
			slot_of = siocr_pkg::SLOT_HOLE;
		end
	endfunction

	// Implemented bits of a slot; the hole and status slots take no writes.
	function automatic logic [31:0] mask_of(input logic [3:0] slot);
		case (slot)
			4'h0, 4'h1: mask_of = siocr_pkg::MASK_BIT;
			4'h2:       mask_of = siocr_pkg::MASK_EDGE;
			4'h3:       mask_of = siocr_pkg::MASK_IOCFG;
			4'h4:       mask_of = siocr_pkg::MASK_PUMP;
			4'h5, 4'h6: mask_of = siocr_pkg::MASK_VSB;
			4'h7:       mask_of = siocr_pkg::MASK_GPSB;
			4'h8:       mask_of = siocr_pkg::MASK_COUNTS;
			4'ha:       mask_of = siocr_pkg::MASK_MODE;
			4'hb:       mask_of = siocr_pkg::MASK_VSB;
			4'hc:       mask_of = siocr_pkg::MASK_FSEL_HI;
			default:    mask_of = 32'h0000_0000;
		endcase
	endfunction

	// Reset value of a slot.
	function automatic logic [31:0] reset_of(input logic [3:0] slot);
		case (slot)
			4'h3:    reset_of = siocr_pkg::RST_IOCFG;
			4'h4:    reset_of = siocr_pkg::RST_PUMP;
			default: reset_of = 32'h0000_0000;
		endcase
	endfunction

	logic [31:0]                 cfg [siocr_pkg::NUM_SLOTS];
	logic [31:0]                 status_word;
	logic [31:0]                 next_cfg;
	logic [31:0]                 byte_mask;
	logic [3:0]                  wr_slot;
	logic [3:0]                  rd_slot;
	logic                        wr_fire;
	logic                        pol_active;
	logic [25:0]                 edge_active;
	logic [12:0]                 px;
	logic [12:0]                 mline;
	logic [12:0]                 line_cnt;
	logic                        ext_line_prev;
	logic                        ext_frame_prev;
	logic                        gen_line_act;
	logic                        gen_frame_act;
	logic                        ext_line_act;
	logic                        ext_frame_act;
	logic                        line_start;
	logic                        frame_start;
	logic                        field_update;
	logic                        role;
	logic [12:0]                 hloc;
	logic [12:0]                 vloc;
	logic [2:0]                  last_pos;
	logic [2:0]                  field_pos;
	siocr_pkg::siocr_out_state_t out_state;

	assign role = cfg[0][0];
	assign hloc = edge_active[siocr_pkg::LSYNC_LSB +: siocr_pkg::LOC_W];
	assign vloc = edge_active[siocr_pkg::FSYNC_LSB +: siocr_pkg::LOC_W];

	// Write channel: address and data are taken together when no response is pending.
	assign wr_fire         = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
	assign s_axi_awready_o = wr_fire;
	assign s_axi_wready_o  = wr_fire;
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign wr_slot         = slot_of(s_axi_awaddr_i);
	assign rd_slot         = slot_of(s_axi_araddr_i);

	// Merges the write data by byte lanes and keeps a valid clock mode on a bad code.
	always_comb begin
		byte_mask = {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
			{8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
		next_cfg = ((cfg[wr_slot] & ~byte_mask) | (s_axi_wdata_i & byte_mask))
			& mask_of(wr_slot);
		if (wr_slot == 4'h3) begin
			case (next_cfg[siocr_pkg::HCLK_LSB +: 3]) // RQ7
				siocr_pkg::HCLK_MODE1, siocr_pkg::HCLK_MODE2, siocr_pkg::HCLK_MODE3: begin
					next_cfg[siocr_pkg::HCLK_LSB +: 3] = next_cfg[siocr_pkg::HCLK_LSB +: 3];
				end
				default: begin
					next_cfg[siocr_pkg::HCLK_LSB +: 3] = cfg[4'h3][siocr_pkg::HCLK_LSB +: 3]; // RQ21
				end
			endcase
		end
	end

	// One storage process per slot except the status slot; immediate registers take effect on the write.
	genvar gi;
	generate
		for (gi = 0; gi < siocr_pkg::NUM_SLOTS - 1; gi++) begin : g_slot
			always_ff @(posedge clock_i) begin
				if (rst_i) begin
					cfg[gi] <= reset_of(4'(gi));
				end else if (wr_fire && wr_slot == 4'(gi)) begin
					cfg[gi] <= next_cfg; // RQ20
				end
			end
		end
	endgenerate
	assign cfg[siocr_pkg::NUM_SLOTS - 1] = status_word;
	assign status_word = {21'h000000, out_state, field_pos, current_field_o};

	// Write response: unmapped or read-only slots answer with a slave error.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= siocr_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= (mask_of(wr_slot) == 32'h0000_0000) ?
				siocr_pkg::RESP_SLVERR : siocr_pkg::RESP_OKAY;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// Read data path; the hole slot reads zero with a slave error.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0000_0000;
			s_axi_rresp_o  <= siocr_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
			s_axi_rvalid_o <= 1'b1;
			if (rd_slot == siocr_pkg::SLOT_HOLE) begin
				s_axi_rdata_o <= 32'h0000_0000;
				s_axi_rresp_o <= siocr_pkg::RESP_SLVERR;
			end else begin
				s_axi_rdata_o <= cfg[rd_slot];
				s_axi_rresp_o <= siocr_pkg::RESP_OKAY;
			end
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// Field-updated copies of polarity and edge locations load only at the update line.
	assign field_update = line_start && (line_cnt == update_line_i);
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pol_active  <= 1'b0;
			edge_active <= 26'h0000000;
		end else if (field_update) begin
			pol_active  <= cfg[1][0]; // RQ18
			edge_active <= cfg[2][25:0]; // RQ20
		end
	end

	// Master pixel and line counters that pace the generated syncs.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			px    <= 13'h0000;
			mline <= 13'h0000;
		end else if (px == siocr_pkg::LINE_PIXELS - 13'h0001) begin
			px    <= 13'h0000;
			mline <= (mline == siocr_pkg::FRAME_LINES - 13'h0001) ? 13'h0000 : mline + 13'h0001;
		end else begin
			px <= px + 13'h0001;
		end
	end

	// Generated activity: the line sync rises at its location, the frame sync on line zero.
	assign gen_line_act  = (px >= hloc) && (px < hloc + siocr_pkg::LSYNC_WIDTH);
	assign gen_frame_act = (mline == 13'h0000 && px >= vloc) ||
		(mline == 13'h0001 && px < vloc); // RQ4
	// External syncs decoded to active-high through the polarity bit.
	assign ext_line_act  = line_sync_in_i ~^ pol_active; // RQ2
	assign ext_frame_act = frame_sync_in_i ~^ pol_active; // RQ2

	// Edge history of the external syncs.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ext_line_prev  <= 1'b0;
			ext_frame_prev <= 1'b0;
		end else begin
			ext_line_prev  <= ext_line_act;
			ext_frame_prev <= ext_frame_act;
		end
	end

	// Line and frame starts come from the generator as master or the pins as slave.
	assign line_start  = role ? (px == hloc) : (ext_line_act && !ext_line_prev); // RQ1
	assign frame_start = role ? (mline == 13'h0000 && px == vloc) :
		(ext_frame_act && !ext_frame_prev); // RQ1

	// Line count within the field, restarted by each frame start.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			line_cnt <= 13'h0000;
		end else if (frame_start) begin
			line_cnt <= 13'h0000;
		end else if (line_start) begin
			line_cnt <= line_cnt + 13'h0001;
		end
	end

	// Sync pins: driven with the programmed polarity only in master role.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			line_sync_out_o   <= 1'b1;
			frame_sync_out_o  <= 1'b1;
			line_sync_oe_n_o  <= 1'b1;
			frame_sync_oe_n_o <= 1'b1;
		end else begin
			line_sync_out_o   <= gen_line_act ~^ pol_active; // RQ2
			frame_sync_out_o  <= gen_frame_act ~^ pol_active; // RQ2
			line_sync_oe_n_o  <= !role; // RQ1
			frame_sync_oe_n_o <= !role; // RQ1
		end
	end

	// Field sequencer: steps through the configured number of fields, zero counts as one.
	assign last_pos = (cfg[4'ha][2:0] == 3'h0) ? 3'h0 : cfg[4'ha][2:0] - 3'h1;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			field_pos <= 3'h0;
		end else if (frame_start) begin
			field_pos <= (field_pos >= last_pos) ? 3'h0 : field_pos + 3'h1; // RQ15
		end
	end

	// Picks the stored field selector for the current sequence position.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			current_field_o <= 5'h00;
		end else if (field_pos < 3'h5) begin
			current_field_o <= cfg[4'hb][{2'h0, field_pos} * 5'h05 +: siocr_pkg::FSEL_W]; // RQ16
		end else begin
			current_field_o <= cfg[4'hc][(field_pos - 3'h5) * 3'h5 +: siocr_pkg::FSEL_W]; // RQ16
		end
	end
	assign field_position_o = field_pos;

	// Output gate: control low holds outputs, control high arms until the next frame start.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			out_state <= siocr_pkg::OUT_OFF;
		end else begin
			case (out_state)
				siocr_pkg::OUT_OFF: begin
					if (output_enable_ctl_i) begin
						out_state <= siocr_pkg::OUT_ARMED;
					end
				end
				siocr_pkg::OUT_ARMED: begin
					if (!output_enable_ctl_i) begin
						out_state <= siocr_pkg::OUT_OFF;
					end else if (frame_start) begin
						out_state <= siocr_pkg::OUT_ON; // RQ19
					end
				end
				siocr_pkg::OUT_ON: begin
					if (!output_enable_ctl_i) begin
						out_state <= siocr_pkg::OUT_OFF; // RQ19
					end
				end
				default: begin
					out_state <= siocr_pkg::OUT_OFF;
				end
			endcase
		end
	end

	// Vertical, substrate and general outputs: standby polarities or live timing.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			vertical_clock_out_o  <= 24'h000000;
			substrate_clock_out_o <= 1'b0;
			general_out_o         <= 8'h00;
		end else if (out_state != siocr_pkg::OUT_ON ||
			(standby_state_i != siocr_pkg::STBY_NONE && standby_state_i != siocr_pkg::STBY_3)) begin
			vertical_clock_out_o  <= cfg[5][siocr_pkg::VERT_N-1:0]; // RQ11
			substrate_clock_out_o <= cfg[5][siocr_pkg::VERT_N]; // RQ11
			general_out_o         <= cfg[7][7:0]; // RQ13
		end else if (standby_state_i == siocr_pkg::STBY_3) begin
			vertical_clock_out_o  <= cfg[6][siocr_pkg::VERT_N-1:0]; // RQ12
			substrate_clock_out_o <= cfg[6][siocr_pkg::VERT_N]; // RQ12
			general_out_o         <= cfg[7][siocr_pkg::GP3_LSB +: 8]; // RQ13
		end else begin
			vertical_clock_out_o  <= vert_timing_i;
			substrate_clock_out_o <= substrate_timing_i;
			general_out_o         <= general_timing_i;
		end
	end

	// Immediate configuration outputs.
	assign osc_range_sel_o       = cfg[3][siocr_pkg::OSC_BIT];
	assign vert_out_range_sel_o  = cfg[3][siocr_pkg::VOUT_BIT];
	assign io_range_sel_o        = cfg[3][siocr_pkg::IORNG_BIT];
	assign data_pin_range_sel_o  = cfg[3][siocr_pkg::DATA_BIT];
	assign regulator_enable_o    = cfg[3][siocr_pkg::REGEN_BIT]; // RQ6
	assign hclk_out_config_o     = cfg[3][siocr_pkg::HCLK_LSB +: 3]; // RQ7
	assign pump_v_sel_o          = cfg[4][siocr_pkg::PUMP_V_LSB +: 4]; // RQ9
	assign pump_power_down_o     = cfg[4][siocr_pkg::PUMP_PD_BIT]; // RQ10
	assign pattern_group_count_o = cfg[8][4:0]; // RQ14
	assign sequence_count_o      = cfg[8][siocr_pkg::SEQ_LSB +: 5]; // RQ14
	// Pump clock source: oscillator, then raw input, otherwise the divided clock.
	assign pump_clk_src_o = cfg[4][siocr_pkg::PUMP_OSC_BIT] ? siocr_pkg::PUMP_SRC_OSC :
		cfg[4][siocr_pkg::PUMP_CLI_BIT] ? siocr_pkg::PUMP_SRC_CLI : siocr_pkg::PUMP_SRC_DIV; // RQ8

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	property p_hclk_valid;
		$onehot(hclk_out_config_o);
	endproperty
	a_hclk_valid: assert property (p_hclk_valid) else $error("Clock mode not one-hot."); // RQ21

	property p_pdn_reset;
		$fell(rst_i) |-> pump_power_down_o && pump_v_sel_o == 4'h4;
	endproperty
	a_pdn_reset: assert property (p_pdn_reset) else $error("Pump reset values wrong."); // RQ10

	property p_master_drives;
		role [*2] |-> !line_sync_oe_n_o && !frame_sync_oe_n_o;
	endproperty
	a_master_drives: assert property (p_master_drives) else $error("Master not driving."); // RQ1

	property p_pol_hold;
		!field_update |=> $stable(pol_active) && $stable(edge_active);
	endproperty
	a_pol_hold: assert property (p_pol_hold) else $error("Field copy changed early."); // RQ18

	property p_frame_rise;
		frame_start && role |=> frame_sync_out_o == $past(pol_active);
	endproperty
	a_frame_rise: assert property (p_frame_rise) else $error("Frame sync not active."); // RQ4

	property p_off_hold;
		out_state == siocr_pkg::OUT_OFF |=> vertical_clock_out_o == $past(cfg[5][23:0]);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("Disabled outputs wrong."); // RQ11

	property p_stby3;
		out_state == siocr_pkg::OUT_ON && standby_state_i == siocr_pkg::STBY_3
			|=> substrate_clock_out_o == $past(cfg[6][24]);
	endproperty
	a_stby3: assert property (p_stby3) else $error("Standby 3 polarity wrong."); // RQ12

	property p_arm;
		out_state == siocr_pkg::OUT_ARMED && frame_start && output_enable_ctl_i
			|=> out_state == siocr_pkg::OUT_ON;
	endproperty
	a_arm: assert property (p_arm) else $error("Outputs not enabled at frame."); // RQ19

	property p_field_wrap;
		frame_start && field_pos >= last_pos |=> field_pos == 3'h0;
	endproperty
	a_field_wrap: assert property (p_field_wrap) else $error("Field sequence did not wrap."); // RQ15
endmodule
`default_nettype wire

//--- dv/siocr_host_model.sv
// Host processor model that sources active-low line and frame syncs for slave operation.
`timescale 1ns/1ps
`default_nettype none
module siocr_host_model (
	input  wire logic clock_i,
	input  wire logic rst_i,
	input  wire logic frame_req_i,
	output logic      line_sync_o,
	output logic      frame_sync_o
);
	logic [5:0] px;
	logic [3:0] fcnt;

	// Free pixel count for line syncs; a request starts an eight-clock frame sync.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			px <= 6'h00;
			fcnt <= 4'h0;
		end else begin
			px <= px + 6'h01;
			fcnt <= frame_req_i ? 4'h8 : fcnt - {3'h0, fcnt != 4'h0};
		end
	end

	// Both syncs are active low, matching the polarity the device holds after reset.
	assign line_sync_o = px >= 6'h04;
	assign frame_sync_o = fcnt == 4'h0;
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking testbench for the sync, I/O and mode configuration register block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clock_i = 1'b0, rst_i = 1'b1, fire = 1'b0, output_enable_ctl_i = 1'b0;
	logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, general_out_o;
	logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, substrate_clock_out_o;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rv;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp, standby_state_i = 2'h0, pump_clk_src_o;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic        lso, lsoe, fso, fsoe, hls, hfs, regulator_enable_o, pump_power_down_o;
	logic [23:0] vertical_clock_out_o;
	logic [2:0]  hclk_out_config_o, fpos;
	logic [3:0]  pump_v_sel_o;
	wire logic [3:0] rng;
	logic [4:0]  pattern_group_count_o, sequence_count_o, cfld;
	int          err_count = 0, n_tests = 0, cnt;

	siocr_regs i_dut (.clock_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
		.s_axi_wdata_i, .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
		.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
		.s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.line_sync_in_i(lsoe ? hls : lso), .line_sync_out_o(lso), .line_sync_oe_n_o(lsoe),
		.frame_sync_in_i(fsoe ? hfs : fso), .frame_sync_out_o(fso), .frame_sync_oe_n_o(fsoe),
		.update_line_i(13'h0002), .output_enable_ctl_i, .standby_state_i,
		.vert_timing_i(24'ha5c3e1), .substrate_timing_i(1'b1), .general_timing_i(8'h3c),
		.vertical_clock_out_o, .substrate_clock_out_o, .general_out_o, .osc_range_sel_o(rng[0]),
		.vert_out_range_sel_o(rng[1]), .io_range_sel_o(rng[2]), .data_pin_range_sel_o(rng[3]),
		.regulator_enable_o, .hclk_out_config_o, .pump_clk_src_o, .pump_v_sel_o,
		.pump_power_down_o, .pattern_group_count_o, .sequence_count_o, .field_position_o(fpos),
		.current_field_o(cfld));
	siocr_host_model i_host (.clock_i, .rst_i, .frame_req_i(fire), .line_sync_o(hls),
		.frame_sync_o(hfs));

	// Free-running 100 MHz clock.
	always #5 clock_i = ~clock_i;

	// Compares a value, counts it and reports a mismatch.
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// AXI4-Lite write; the response code lands in resp.
	task wr(input logic [5:0] idx, input logic [31:0] d);
		@(posedge clock_i);
		s_axi_awaddr_i <= {idx, 2'b00};
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do @(posedge clock_i); while (s_axi_awready_o !== 1'b1);
		s_axi_awvalid_i <= 1'b0;
		s_axi_wvalid_i <= 1'b0;
		do @(posedge clock_i); while (s_axi_bvalid_o !== 1'b1);
		resp = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
	endtask

	// AXI4-Lite read; data land in rv and the response code in resp.
	task rd(input logic [5:0] idx);
		@(posedge clock_i);
		s_axi_araddr_i <= {idx, 2'b00};
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do @(posedge clock_i); while (s_axi_arready_o !== 1'b1);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge clock_i); while (s_axi_rvalid_o !== 1'b1);
		rv = s_axi_rdata_o;
		resp = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
	endtask

	// Reset values of the I/O and pump registers, the pump outputs and the sync pin enables.
	task t_reset;
		rd(siocr_pkg::IDX_IOCFG);
		chk(rv, 32'h0000_0080);
		rd(siocr_pkg::IDX_PUMP);
		chk(rv, 32'h0000_47a2);
		chk(pump_clk_src_o, siocr_pkg::PUMP_SRC_DIV);
		chk(pump_v_sel_o, 4'h4);
		chk(pump_power_down_o, 1'b1);
		chk({lsoe, fsoe}, 2'h3);
	endtask

	// Every one-hot clock mode, then an invalid code that must leave mode 3 in place.
	task t_hclk;
		logic [2:0] codes [3];
		codes = '{siocr_pkg::HCLK_MODE1, siocr_pkg::HCLK_MODE2, siocr_pkg::HCLK_MODE3};
		foreach (codes[i]) begin
			wr(siocr_pkg::IDX_IOCFG, {22'h0, codes[i], 7'h4a});
			chk(hclk_out_config_o, codes[i]);
			chk(rng, 4'ha);
			chk(regulator_enable_o, 1'b1);
		end
		wr(siocr_pkg::IDX_IOCFG, 32'h0000_0181);
		chk(hclk_out_config_o, siocr_pkg::HCLK_MODE3);
		chk(rng, 4'h1);
		rd(siocr_pkg::IDX_IOCFG);
		chk(rv, 32'h0000_0201);
	endtask

	// Pump clock source priority, voltage selects and power-down.
	task t_pump;
		wr(siocr_pkg::IDX_PUMP, 32'h0000_0794);
		chk(pump_clk_src_o, siocr_pkg::PUMP_SRC_CLI);
		chk(pump_v_sel_o, 4'h2);
		chk(pump_power_down_o, 1'b0);
		wr(siocr_pkg::IDX_PUMP, 32'h0000_478d);
		chk(pump_clk_src_o, siocr_pkg::PUMP_SRC_OSC);
		chk(pump_v_sel_o, 4'h1);
	endtask

	// Counts register outputs, then a hole and the read-only status place.
	task t_map;
		wr(siocr_pkg::IDX_COUNTS, 32'h0000_03a7);
		chk(pattern_group_count_o, 5'h07);
		chk(sequence_count_o, 5'h1d);
		rd(6'h29);
		chk({rv, resp}, {32'h0, siocr_pkg::RESP_SLVERR});
		wr(siocr_pkg::IDX_STATUS, 32'h0000_00ff);
		chk(resp, siocr_pkg::RESP_SLVERR);
	endtask

	// Output gate and standby polarities across a frame start from the host.
	task t_gate;
		wr(siocr_pkg::IDX_VSB12, 32'h0123_45ab);
		wr(siocr_pkg::IDX_VSB3, 32'h00ab_cdef);
		wr(siocr_pkg::IDX_GPSB, 32'h0000_5aa5);
		output_enable_ctl_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		chk({substrate_clock_out_o, vertical_clock_out_o, general_out_o}, 33'h1_2345_aba5);
		fire <= 1'b1;
		@(posedge clock_i);
		fire <= 1'b0;
		repeat (5) @(posedge clock_i);
		chk({substrate_clock_out_o, vertical_clock_out_o, general_out_o}, 33'h1_a5c3_e13c);
		standby_state_i <= siocr_pkg::STBY_3;
		repeat (3) @(posedge clock_i);
		chk({substrate_clock_out_o, vertical_clock_out_o, general_out_o}, 33'h0_abcd_ef5a);
		standby_state_i <= 2'h1;
		repeat (3) @(posedge clock_i);
		chk({substrate_clock_out_o, vertical_clock_out_o, general_out_o}, 33'h1_2345_aba5);
	endtask

	// Seven-position field sequence stepped by host frame starts, wrapping after the last.
	task t_field;
		wr(siocr_pkg::IDX_FSEL_LO, {7'h00, 5'h15, 5'h14, 5'h13, 5'h12, 5'h11});
		wr(siocr_pkg::IDX_FSEL_HI, {22'h000000, 5'h17, 5'h16});
		wr(siocr_pkg::IDX_MODE, 32'h0000_0007);
		for (int i = 0; i < 8; i++) begin
			repeat (2) @(posedge clock_i);
			chk(fpos, i % 7);
			chk(cfld, 5'h11 + i % 7);
			fire <= 1'b1;
			@(posedge clock_i);
			fire <= 1'b0;
			repeat (10) @(posedge clock_i);
		end
	endtask

	// Edges and high polarity load at the update line, then master drives 16-clock pulses.
	task t_master;
		wr(siocr_pkg::IDX_EDGE, 32'h00a0_0064);
		wr(siocr_pkg::IDX_POL, 32'h0000_0001);
		fire <= 1'b1;
		@(posedge clock_i);
		fire <= 1'b0;
		repeat (250) @(posedge clock_i);
		wr(siocr_pkg::IDX_ROLE, 32'h0000_0001);
		repeat (3) @(posedge clock_i);
		chk({lsoe, fsoe}, 2'h0);
		cnt = 0;
		repeat (1560) begin
			@(posedge clock_i);
			cnt += (lso === 1'b1);
		end
		chk(cnt, 16);
	endtask

	// Prints the verdict and ends the run.
	task end_of_test;
		if (err_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence after six cycles of reset.
	initial begin
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		t_reset();
		t_hclk();
		t_pump();
		t_map();
		t_gate();
		t_field();
		t_master();
		end_of_test();
	end

	// Watchdog sized well beyond the expected few thousand cycles.
	initial begin
		repeat (20000) @(posedge clock_i);
		err_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
